//--- core/adcc_pkg.sv
// Package with constants and carrier types of the converter control block
package adcc_pkg;
	localparam logic [7:0] ADDR_CONTROL   = 8'hC0;
	localparam logic [7:0] ADDR_RESULT    = 8'hC5;
	localparam logic [7:0] ADDR_IEN1      = 8'hE8;
	localparam logic [7:0] ADDR_GATE      = 8'hF6;
	localparam int BIT_ENABLE    = 7;
	localparam int BIT_DONE      = 4;
	localparam int BIT_START     = 3;
	localparam int BIT_IRQ_EN    = 4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Successive approximation: one bit per cycle plus sample cycle
	localparam int CONV_BITS     = 8;
	localparam logic [3:0] CONV_CYCLES = 4'h9;
	localparam int SETTLE_US     = 10;
	localparam int CLK_MHZ       = 100;
	localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		ADCC_IDLE = 2'b01,
		ADCC_CONV = 2'b10
	} adcc_state_t;

	typedef struct packed {
		adcc_state_t state;
		logic        enable;
		logic        start_busy;
		logic        done;
		logic [1:0]  channel;
		logic        irq_en;
		logic [3:0]  count;
		logic [7:0]  trial;
		logic [7:0]  result;
		logic [7:0]  gate;
		logic [7:0] port0_s1;
		logic [7:0] port0_s2;
		logic [7:0] port0_read;
		logic [7:0] rdata;
		logic        irq;
		logic        result_dac_oe;
		logic [1:0]  mux_sel;
	} adcc_regs_t;
endpackage : adcc_pkg

//--- core/adcc_top.sv
// Converter control logic with its special function registers
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       global_irq_en,
	input  wire logic       irq_highest,
	input  wire logic       comparator_hi,
	input  wire logic [7:0] port0_pins,
	output logic      [7:0] port0_read,
	output logic      [7:0] port0_input_off,
	output logic      [1:0] mux_sel,
	output logic      [7:0] sar_trial,
	output logic      [7:0] shared_result_value,
	output logic            result_dac_oe,
	output logic            conv_irq
);
	adcc_pkg::adcc_regs_t r;
	adcc_pkg::adcc_regs_t next_r;
	logic wr_ctl;
	logic go;
	logic fin;

	// Next-state logic; one clean path per register
	always_comb begin
		next_r = r;
		wr_ctl = sfr_wr && sfr_addr == adcc_pkg::ADDR_CONTROL;
		// Start blocked while busy or done still set
		go = wr_ctl && sfr_wdata[adcc_pkg::BIT_START] && !r.start_busy
			&& !r.done && r.enable;
		fin = r.state == adcc_pkg::ADCC_CONV
			&& r.count == adcc_pkg::CONV_CYCLES;
		if (wr_ctl) begin
			// Disable refused while busy or done
			if (sfr_wdata[adcc_pkg::BIT_ENABLE] || (!r.start_busy && !r.done))
				next_r.enable = sfr_wdata[adcc_pkg::BIT_ENABLE];
			// Writing zero clears done; hardware set below wins
			if (!sfr_wdata[adcc_pkg::BIT_DONE])
				next_r.done = 1'b0;
			// Channel changes only with an accepted start
			if (go)
				next_r.channel = sfr_wdata[1:0];
		end
		if (sfr_wr && sfr_addr == adcc_pkg::ADDR_IEN1)
			next_r.irq_en = sfr_wdata[adcc_pkg::BIT_IRQ_EN];
		if (sfr_wr && sfr_addr == adcc_pkg::ADDR_GATE)
			next_r.gate = sfr_wdata;
		// Sequencer: one sample cycle, then one cycle per result bit
		unique case (r.state)
			adcc_pkg::ADCC_IDLE: begin
				if (go) begin
					next_r.state = adcc_pkg::ADCC_CONV;
					next_r.start_busy = 1'b1;
					next_r.count = 4'h0;
					next_r.trial = 8'h80;
				end
			end
			adcc_pkg::ADCC_CONV: begin
				next_r.count = r.count + 4'h1;
				if (r.count != 4'h0 && !fin) begin
					// Count one decides the MSB; constant indices only,
					// so no select ever runs below bit zero
					for (int i = 0; i < adcc_pkg::CONV_BITS; i++) begin
						if (int'(r.count) == adcc_pkg::CONV_BITS - i
							&& !comparator_hi)
							next_r.trial[i] = 1'b0;
						if (int'(r.count) == adcc_pkg::CONV_BITS - 1 - i)
							next_r.trial[i] = 1'b1;
					end
				end
				if (fin) begin
					next_r.state = adcc_pkg::ADCC_IDLE;
					next_r.start_busy = 1'b0;
					next_r.done = 1'b1;
					next_r.result = r.trial;
				end
			end
		endcase
		// Input buffers gated; disabled bits read zero
		next_r.port0_s1 = port0_pins;
		next_r.port0_s2 = r.port0_s1;
		next_r.port0_read = r.port0_s2 & ~r.gate;
		// Read mux; unmapped addresses read zero
		next_r.rdata = adcc_pkg::RESET_BYTE;
		if (sfr_rd) begin
			unique case (sfr_addr)
				adcc_pkg::ADDR_CONTROL: next_r.rdata = {r.enable, 2'b00,
					r.done, r.start_busy, 1'b0, r.channel};
				adcc_pkg::ADDR_RESULT: next_r.rdata = r.result;
				adcc_pkg::ADDR_IEN1: next_r.rdata = {3'b000, r.irq_en, 4'h0};
				adcc_pkg::ADDR_GATE: next_r.rdata = r.gate;
				default: next_r.rdata = adcc_pkg::RESET_BYTE;
			endcase
		end
		// Registered outputs; the interrupt lags done by one cycle
		next_r.irq = r.done && r.irq_en && global_irq_en && irq_highest;
		next_r.result_dac_oe = !r.enable;
		next_r.mux_sel = r.channel;
	end

	// State register; reset to constants only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r <= '{state: adcc_pkg::ADCC_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign sfr_rdata = r.rdata;
	assign port0_read = r.port0_read;
	assign port0_input_off = r.gate;
	assign mux_sel = r.mux_sel;
	assign sar_trial = r.trial;
	assign shared_result_value = r.result;
	assign result_dac_oe = r.result_dac_oe;
	assign conv_irq = r.irq;

	// Channel frozen while busy; loaded only by an accepted start
	chan_hold_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.start_busy |=> $stable(r.channel) || !$past(r.start_busy))
		else $error("channel changed during conversion");
	chan_load_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		go |=> r.channel == $past(sfr_wdata[1:0]))
		else $error("channel not taken with accepted start");

	// A write that only clears done leaves the channel alone
	chan_clear_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		wr_ctl && !go |=> $stable(r.channel))
		else $error("channel changed without a start");
	sar_first_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		go |=> r.trial == 8'h80)
		else $error("first trial code not mid scale");

	// Busy rises on the start edge and is checked high for the next eight cycles
	start_set_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		go |=> r.start_busy && r.state == adcc_pkg::ADCC_CONV)
		else $error("start not reported as busy");
	start_busy_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		go && r.state == adcc_pkg::ADCC_IDLE |=> r.start_busy [*8])
		else $error("busy not held during conversion");

	// Busy and done change on one edge at completion
	finish_pair_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(r.start_busy) |-> $rose(r.done))
		else $error("busy and done not updated together");
	done_set_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		fin |=> r.done && !r.start_busy)
		else $error("done not set at completion");

	// Busy stays up for ten samples; done blocks a restart
	conv_len_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(r.start_busy) |-> ##10 $fell(r.start_busy))
		else $error("conversion length wrong");
	no_restart_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.done && !r.start_busy |=> !r.start_busy)
		else $error("conversion started with done set");

	// Interrupt follows its four conditions one cycle late
	irq_gate_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.irq |-> $past(r.done && r.irq_en && global_irq_en && irq_highest))
		else $error("interrupt without cause");
	irq_raise_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.done && r.irq_en && global_irq_en && irq_highest |=> r.irq)
		else $error("interrupt missing");

	// Result loads only at completion and then holds
	result_hold_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!r.start_busy && !$past(r.start_busy) |-> $stable(r.result))
		else $error("result changed outside conversion");
	result_load_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		fin |=> r.result == $past(r.trial))
		else $error("result not loaded at completion");

	// Shared value register: the pin is driven only when disabled
	dac_pin_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.enable |=> !r.result_dac_oe)
		else $error("dac driven while converter enabled");
	dac_drive_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!r.enable |=> r.result_dac_oe)
		else $error("dac not driven while converter disabled");

	// Gate register loads from the bus and masks port reads
	gate_load_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		sfr_wr && sfr_addr == adcc_pkg::ADDR_GATE |=> r.gate == $past(sfr_wdata))
		else $error("gate register not written");
	gate_read_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		##1 (r.port0_read & $past(r.gate)) == 8'h00)
		else $error("disabled port bit read as one");

	// Enable stays while work is pending; mux follows the channel
	enable_keep_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.enable && (r.start_busy || r.done) |=> r.enable)
		else $error("enable cleared while busy or done");
	mux_follow_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		##1 r.mux_sel == $past(r.channel))
		else $error("mux select does not follow channel");
endmodule : adcc_top
`default_nettype wire

//--- tb/adcc_analog_model.sv
// Analog source model: four fixed levels behind the channel mux
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
	input  wire logic [1:0] mux_sel,
	input  wire logic [7:0] sar_trial,
	output logic            comparator_hi
);
	logic [7:0] level [4];
	// One level at full scale so every trial bit must stay set
	assign level = '{8'h3C, 8'hA5, 8'hFF, 8'h01};
	// Ideal comparator, so the code equals the level exactly
	assign comparator_hi = level[mux_sel] >= sar_trial;
endmodule : adcc_analog_model
`default_nettype wire

//--- tb/test_adcc_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adcc_top;
	logic       clk_sys, reset_n, sfr_wr, sfr_rd, comparator_hi;
	logic       global_irq_en, irq_highest, result_dac_oe, conv_irq;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port0_pins, port0_read;
	logic [7:0] port0_input_off, sar_trial, shared_result_value;
	logic [1:0] mux_sel;
	int         n_fail = 0;
	int         num_checks = 0;
	adcc_top DUT (.clk_sys, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .global_irq_en, .irq_highest,
		.comparator_hi, .port0_pins, .port0_read, .port0_input_off,
		.mux_sel, .sar_trial, .shared_result_value, .result_dac_oe,
		.conv_irq);
	adcc_analog_model model (.mux_sel, .sar_trial, .comparator_hi);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles: one-cycle strobes launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk_sys);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
	endtask : rdc
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic t_reset;
		rdc(8'hC0, 8'h00);
		rdc(8'h55, 8'h00);
		chk({7'h0, result_dac_oe}, 8'h01);
		$display("reset test done");
	endtask : t_reset
	// Conversion, refusals while busy or done, interrupt gating
	task automatic t_conv;
		wr(8'hC0, 8'h80);
		repeat (1000) @(negedge clk_sys);
		chk({7'h0, result_dac_oe}, 8'h00);
		wr(8'hF6, 8'h0F);
		wr(8'hC0, 8'h8A);
		rdc(8'hC0, 8'h8A);
		wr(8'hC0, 8'h89);
		chk({6'h0, mux_sel}, 8'h02);
		repeat (12) @(negedge clk_sys);
		rdc(8'hC0, 8'h92);
		rdc(8'hC5, 8'hFF);
		chk(sar_trial, 8'hFF);
		// Bit 4 written as one keeps done set for both refusals
		wr(8'hC0, 8'h10);
		wr(8'hC0, 8'h98);
		rdc(8'hC0, 8'h92);
		wr(8'hE8, 8'h10);
		global_irq_en = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk({7'h0, conv_irq}, 8'h01);
		irq_highest = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({7'h0, conv_irq}, 8'h00);
		wr(8'hC0, 8'h81);
		rdc(8'hC0, 8'h82);
		chk(shared_result_value, 8'hFF);
		wr(8'hC0, 8'h89);
		repeat (12) @(negedge clk_sys);
		rdc(8'hC5, 8'hA5);
		rdc(8'hC0, 8'h91);
		$display("conversion test done");
	endtask : t_conv
	task automatic t_gate;
		wr(8'hF6, 8'hF0);
		repeat (3) @(negedge clk_sys);
		chk(port0_read, 8'h0F);
		chk(port0_input_off, 8'hF0);
		rdc(8'hF6, 8'hF0);
		// New pin levels pass the two-flop synchroniser first
		port0_pins = 8'hA5;
		repeat (4) @(negedge clk_sys);
		chk(port0_read, 8'h05);
		$display("gate test done");
	endtask : t_gate
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Watchdog: tests need about 1100 cycles
	initial begin
		#50000;
		n_fail++;
		stop_test();
	end
	initial begin
		{reset_n, sfr_wr, sfr_rd, global_irq_en} = 4'h0;
		irq_highest = 1'b1;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		port0_pins = 8'hFF;
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		t_reset();
		t_conv();
		t_gate();
		stop_test();
	end
endmodule : test_adcc_top
`default_nettype wire
